// ==== include/pfm_pkg.sv ====
/*
 * Shared constants and types for the pad function multiplexer: register
 * addresses, control field layout, reset images, legal mode masks per ball.
 * Assumes a 32-bit main-subsystem address space with word-wide accesses.
 */
package pfm_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_PADS = 10;
    localparam int MODE_W = 4;
    localparam int NUM_MODES = 16;
    localparam int REG_W = 32;

    // ----------------------------------------------------------------
    // Ball indices, ordered by control address
    // ----------------------------------------------------------------
    localparam int PAD_HOST_ATTN = 0;
    localparam int PAD_SB_OUT = 1;
    localparam int PAD_SB_IN = 2;
    localparam int PAD_RESTART = 3;
    localparam int PAD_JTAG_CLK = 4;
    localparam int PAD_JTAG_MODE = 5;
    localparam int PAD_JTAG_DIN = 6;
    localparam int PAD_JTAG_DOUT = 7;
    localparam int PAD_SYNC_IN = 8;
    localparam int PAD_SYNC_OUT = 9;

    // ----------------------------------------------------------------
    // Control register addresses
    // ----------------------------------------------------------------
    localparam logic [31:0] ADDR_HOST_ATTENTION = 32'hffffea00;
    localparam logic [31:0] ADDR_SERIAL_B_OUT = 32'hffffea1c;
    localparam logic [31:0] ADDR_SERIAL_B_IN = 32'hffffea20;
    localparam logic [31:0] ADDR_RESTART_LINE = 32'hffffea48;
    localparam logic [31:0] ADDR_JTAG_CLOCK = 32'hffffea50;
    localparam logic [31:0] ADDR_JTAG_MODE_SELECT = 32'hffffea54;
    localparam logic [31:0] ADDR_JTAG_DATA_IN = 32'hfffea58;
    localparam logic [31:0] ADDR_JTAG_DATA_IN_ALIAS = 32'hffffea58;
    localparam logic [31:0] ADDR_JTAG_DATA_OUT = 32'hffffea5c;
    localparam logic [31:0] ADDR_FRAME_SYNC_IN = 32'hffffea6c;
    localparam logic [31:0] ADDR_FRAME_SYNC_OUT = 32'hffffea70;

    localparam logic [NUM_PADS-1:0][31:0] ADDR_TABLE = {
        ADDR_FRAME_SYNC_OUT, ADDR_FRAME_SYNC_IN, ADDR_JTAG_DATA_OUT,
        ADDR_JTAG_DATA_IN, ADDR_JTAG_MODE_SELECT, ADDR_JTAG_CLOCK,
        ADDR_RESTART_LINE, ADDR_SERIAL_B_IN, ADDR_SERIAL_B_OUT,
        ADDR_HOST_ATTENTION};

    // ----------------------------------------------------------------
    // Field positions of a pad control register
    // ----------------------------------------------------------------
    localparam int FUNC_LSB = 0;
    localparam int IN_FORCE_BIT = 4;
    localparam int IN_VALUE_BIT = 5;
    localparam int OE_FORCE_BIT = 6;
    localparam int OE_VALUE_BIT = 7;
    localparam int PULL_INHIBIT_BIT = 8;
    localparam int PULL_DIR_BIT = 9;
    localparam int SLEW_BIT = 10;

    // Legal modes per ball, bit n set means mode n exists
    localparam logic [NUM_PADS-1:0][15:0] MODE_MASK = {
        16'h0e03,
        16'h02c3,
        16'h02c7,
        16'h0007,
        16'h0047,
        16'h0107,
        16'h0001,
        16'h0047,
        16'h0007,
        16'h0047};

    // Power-on images: output override set, pulls as the ball allows
    localparam logic [NUM_PADS-1:0][31:0] RESET_VALUE = {
        32'h000000c1, 32'h000000c1, 32'h00000141, 32'h000002c1,
        32'h000000c1, 32'h000000c1, 32'h000001c0, 32'h000002c1,
        32'h000002c1, 32'h000000c1};

    // Balls fitted with an internal pull resistor
    localparam logic [NUM_PADS-1:0] HAS_PULL = 10'h377;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [20:0] spare;
        logic slew_low;
        logic pull_direction_select;
        logic pull_inhibit;
        logic oe_value;
        logic oe_force;
        logic input_forced_value;
        logic input_force;
        logic [MODE_W-1:0] function_select;
    } pfm_pad_ctl_t;

    typedef struct packed {
        logic out;
        logic oe;
        logic pull_en;
        logic pull_up;
    } pfm_pad_drive_t;

    typedef enum logic {ST_SAMPLE, ST_RUN} pfm_strap_state_t;

endpackage

// ==== rtl/pfm_pad_function_mux.sv ====
/*
 * Pad function multiplexer for ten balls: per-ball control registers,
 * mode routing, pull and override control, boot strap capture.
 * Assumes a simple synchronous memory-mapped port and synchronous pad inputs.
 */
`timescale 1ns/1ps

module pfm_pad_function_mux (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [31:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output logic reg_ack_out,
    output logic reg_err_out,
    input wire logic [pfm_pkg::NUM_PADS-1:0] pad_in_in,
    output pfm_pkg::pfm_pad_drive_t [pfm_pkg::NUM_PADS-1:0] pad_drive_out,
    input wire logic [pfm_pkg::NUM_PADS-1:0][15:0] periph_out_in,
    input wire logic [pfm_pkg::NUM_PADS-1:0][15:0] periph_oe_in,
    output logic [pfm_pkg::NUM_PADS-1:0][15:0] periph_in_out,
    output logic [1:0] boot_sense_strap_out,
    output logic strap_valid_out
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------

    // Address to {hit, index}; the ball with two printed addresses answers both
    function automatic logic [4:0] decode_addr(input logic [31:0] addr);
        logic [4:0] res;
        res = 5'h00;
        for (int i = 0; i < pfm_pkg::NUM_PADS; i++) begin
            if (addr == pfm_pkg::ADDR_TABLE[i]) begin
                res = {1'b1, 4'(i)};
            end
        end
        if (addr == pfm_pkg::ADDR_JTAG_DATA_IN_ALIAS) begin
            res = {1'b1, 4'(pfm_pkg::PAD_JTAG_DIN)};
        end
        return res;
    endfunction

    // Whether a mode code is listed for a ball
    function automatic logic mode_ok(input int pad, input logic [3:0] sel);
        return pfm_pkg::MODE_MASK[pad][sel];
    endfunction

    // Pull drive from a control word; absent resistors stay off
    function automatic logic [1:0] pull_of(input int pad,
                                           input pfm_pkg::pfm_pad_ctl_t c);
        logic en;
        en = pfm_pkg::HAS_PULL[pad] & ~c.pull_inhibit;
        return {en, en & c.pull_direction_select};
    endfunction

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    pfm_pkg::pfm_pad_ctl_t [pfm_pkg::NUM_PADS-1:0] ctl;
    logic [4:0] dec;
    logic hit;
    logic [3:0] idx;
    pfm_pkg::pfm_strap_state_t strap_state;

    assign dec = decode_addr(reg_addr_in);
    assign hit = dec[4];
    assign idx = dec[3:0];

    // Control words; every bit is kept so software sees what it wrote
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < pfm_pkg::NUM_PADS; i++) begin
                ctl[i] <= pfm_pkg::RESET_VALUE[i];
            end
        end else if (reg_wr_in && hit) begin
            ctl[idx] <= reg_wdata_in;
        end
    end

    // Read data and acknowledge, one cycle after the request
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 32'h00000000;
            reg_ack_out <= 1'b0;
            reg_err_out <= 1'b0;
        end else begin
            reg_ack_out <= reg_rd_in | reg_wr_in;
            reg_err_out <= (reg_rd_in | reg_wr_in) & ~hit;
            if (reg_rd_in) begin
                reg_rdata_out <= hit ? ctl[idx] : 32'h00000000;
            end
        end
    end

    // ----------------------------------------------------------------
    // Function routing
    // ----------------------------------------------------------------
    pfm_pkg::pfm_pad_drive_t [pfm_pkg::NUM_PADS-1:0] next_drive;
    logic [pfm_pkg::NUM_PADS-1:0][15:0] next_periph_in;

    // Only the selected mode reaches the ball; unlisted codes float it unless oe_force is set
    always_comb begin
        logic [3:0] sel;
        logic ok;
        logic seen;
        logic [1:0] pl;
        sel = 4'h0;
        ok = 1'b0;
        seen = 1'b0;
        pl = 2'b00;
        for (int p = 0; p < pfm_pkg::NUM_PADS; p++) begin
            sel = ctl[p].function_select;
            ok = mode_ok(p, sel);
            seen = ctl[p].input_force ? ctl[p].input_forced_value
                                      : pad_in_in[p];
            pl = pull_of(p, ctl[p]);
            next_drive[p].out = ok & periph_out_in[p][sel];
            if (ctl[p].oe_force) begin
                // Override wins over the peripheral; bit high keeps driver off
                next_drive[p].oe = ~ctl[p].oe_value;
            end else begin
                next_drive[p].oe = ok & periph_oe_in[p][sel];
            end
            next_drive[p].pull_en = pl[1];
            next_drive[p].pull_up = pl[0];
            next_periph_in[p] = ok ? ({15'h0000, seen} << sel) : 16'h0000;
        end
    end

    // Registered pad and peripheral side; reset shows the power-on image
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int p = 0; p < pfm_pkg::NUM_PADS; p++) begin
                pad_drive_out[p].out <= 1'b0;
                pad_drive_out[p].oe <= ~pfm_pkg::RESET_VALUE[p][pfm_pkg::OE_VALUE_BIT];
                pad_drive_out[p].pull_en <= pfm_pkg::HAS_PULL[p]
                    & ~pfm_pkg::RESET_VALUE[p][pfm_pkg::PULL_INHIBIT_BIT];
                pad_drive_out[p].pull_up <= pfm_pkg::HAS_PULL[p]
                    & pfm_pkg::RESET_VALUE[p][pfm_pkg::PULL_DIR_BIT];
            end
            periph_in_out <= '0;
        end else begin
            pad_drive_out <= next_drive;
            periph_in_out <= next_periph_in;
        end
    end

    // ----------------------------------------------------------------
    // Boot strap capture
    // ----------------------------------------------------------------

    // One sample on the first edge after release, while pads hold reset state
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            strap_state <= pfm_pkg::ST_SAMPLE;
            boot_sense_strap_out <= 2'b00;
            strap_valid_out <= 1'b0;
        end else begin
            case (strap_state)
                pfm_pkg::ST_SAMPLE: begin
                    boot_sense_strap_out <= {pad_in_in[pfm_pkg::PAD_SYNC_OUT],
                                             pad_in_in[pfm_pkg::PAD_JTAG_DOUT]};
                    strap_valid_out <= 1'b1;
                    strap_state <= pfm_pkg::ST_RUN;
                end
                pfm_pkg::ST_RUN: begin
                    strap_valid_out <= 1'b1;
                end
                default: begin
                    strap_state <= pfm_pkg::ST_RUN;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    logic wr_hit_q;
    logic [3:0] wr_idx_q;
    logic [31:0] wr_data_q;

    // Helper copy of the previous cycle's write bus, flagged when it was accepted
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_hit_q <= 1'b0;
            wr_idx_q <= 4'h0;
            wr_data_q <= 32'h00000000;
        end else begin
            wr_hit_q <= reg_wr_in & hit;
            wr_idx_q <= idx;
            wr_data_q <= reg_wdata_in;
        end
    end

    AST_WRITE_STORED: assert property (
        wr_hit_q |-> ctl[wr_idx_q] == wr_data_q)
        else $error("pad control write not stored");

    AST_READBACK: assert property (
        (reg_rd_in && hit && !reg_wr_in) |=> reg_rdata_out == $past(ctl[idx]))
        else $error("pad control readback mismatch");

    AST_UNMAPPED: assert property (
        (reg_rd_in && !hit) |=> reg_err_out && reg_ack_out && reg_rdata_out == 32'h0)
        else $error("unmapped read not answered with zero and error");

    AST_MODE_ZERO: assert property (
        (ctl[pfm_pkg::PAD_HOST_ATTN].function_select == 4'h0)
        |=> pad_drive_out[pfm_pkg::PAD_HOST_ATTN].out
            == $past(periph_out_in[pfm_pkg::PAD_HOST_ATTN][0]))
        else $error("mode zero does not route the default signal");

    AST_SB_IN_UART: assert property (
        (ctl[pfm_pkg::PAD_SB_IN].function_select == 4'h6
         && !ctl[pfm_pkg::PAD_SB_IN].oe_force)
        |=> pad_drive_out[pfm_pkg::PAD_SB_IN].oe
            == $past(periph_oe_in[pfm_pkg::PAD_SB_IN][6]))
        else $error("serial B input ball mode 6 not routed");

    AST_LOW_BITS_ONLY: assert property (
        (ctl[pfm_pkg::PAD_JTAG_CLK][3:0] == 4'h8 && !ctl[pfm_pkg::PAD_JTAG_CLK].input_force)
        |=> periph_in_out[pfm_pkg::PAD_JTAG_CLK] == {7'h00, $past(pad_in_in[4]), 8'h00})
        else $error("mode code beyond low nibble changed routing");

    AST_NO_PULL: assert property (
        !pad_drive_out[pfm_pkg::PAD_JTAG_DOUT].pull_en
        && !pad_drive_out[pfm_pkg::PAD_RESTART].pull_en)
        else $error("pull enabled on a ball without a resistor");

    AST_PULL_CTRL: assert property (
        ##1 pad_drive_out[pfm_pkg::PAD_SB_OUT].pull_en
            == !$past(ctl[pfm_pkg::PAD_SB_OUT][pfm_pkg::PULL_INHIBIT_BIT])
        && pad_drive_out[pfm_pkg::PAD_SB_OUT].pull_up
            == ($past(ctl[1][pfm_pkg::PULL_DIR_BIT]) && !$past(ctl[1][8])))
        else $error("pull control bits not applied");

    AST_OE_OVERRIDE: assert property (
        ctl[pfm_pkg::PAD_JTAG_DOUT].oe_force
        |=> pad_drive_out[pfm_pkg::PAD_JTAG_DOUT].oe
            == !$past(ctl[pfm_pkg::PAD_JTAG_DOUT].oe_value))
        else $error("output override not applied");

    AST_IN_FORCE: assert property (
        (ctl[pfm_pkg::PAD_SB_OUT].input_force
         && ctl[pfm_pkg::PAD_SB_OUT].function_select == 4'h1)
        |=> periph_in_out[pfm_pkg::PAD_SB_OUT][1]
            == $past(ctl[pfm_pkg::PAD_SB_OUT].input_forced_value))
        else $error("input override not applied");

    AST_UNLISTED: assert property (
        (ctl[pfm_pkg::PAD_SYNC_OUT].function_select == 4'h5
         && !ctl[pfm_pkg::PAD_SYNC_OUT].oe_force)
        |=> !pad_drive_out[pfm_pkg::PAD_SYNC_OUT].oe
            && periph_in_out[pfm_pkg::PAD_SYNC_OUT] == 16'h0000)
        else $error("unlisted mode still connected");

    AST_STRAP_SAMPLE: assert property (
        (strap_state == pfm_pkg::ST_SAMPLE)
        |=> strap_valid_out && boot_sense_strap_out
            == $past({pad_in_in[pfm_pkg::PAD_SYNC_OUT], pad_in_in[pfm_pkg::PAD_JTAG_DOUT]}))
        else $error("boot strap not captured on first edge");

    AST_STRAP_HOLD: assert property (
        strap_valid_out |=> (strap_valid_out && $stable(boot_sense_strap_out)) [*4])
        else $error("boot strap changed after capture");

    AST_RESET_DRIVE: assert property (
        (strap_state == pfm_pkg::ST_SAMPLE)
        |-> pad_drive_out[pfm_pkg::PAD_JTAG_DOUT].oe
            && !pad_drive_out[pfm_pkg::PAD_HOST_ATTN].oe
            && pad_drive_out[pfm_pkg::PAD_JTAG_DIN].pull_up)
        else $error("pad not in power-on state");

    AST_SB_OUT_I2C: assert property (
        (ctl[pfm_pkg::PAD_SB_OUT].function_select == 4'h2)
        |=> pad_drive_out[pfm_pkg::PAD_SB_OUT].out
            == $past(periph_out_in[pfm_pkg::PAD_SB_OUT][2]))
        else $error("serial B output ball mode 2 not routed");

    AST_HOST_CHIP_SEL: assert property (
        (ctl[pfm_pkg::PAD_HOST_ATTN].function_select == 4'h6
         && !ctl[pfm_pkg::PAD_HOST_ATTN].input_force)
        |=> periph_in_out[pfm_pkg::PAD_HOST_ATTN]
            == {9'h0, $past(pad_in_in[pfm_pkg::PAD_HOST_ATTN]), 6'h00})
        else $error("host attention ball mode 6 not routed");

    AST_SYNC_IN_TRACE: assert property (
        (ctl[pfm_pkg::PAD_SYNC_IN].function_select == 4'h7
         && !ctl[pfm_pkg::PAD_SYNC_IN].input_force)
        |=> periph_in_out[pfm_pkg::PAD_SYNC_IN]
            == {8'h00, $past(pad_in_in[pfm_pkg::PAD_SYNC_IN]), 7'h00})
        else $error("sync input ball mode 7 not routed");

    AST_MODE_SEL_CAN: assert property (
        (ctl[pfm_pkg::PAD_JTAG_MODE].function_select == 4'h6
         && !ctl[pfm_pkg::PAD_JTAG_MODE].oe_force)
        |=> pad_drive_out[pfm_pkg::PAD_JTAG_MODE].oe
            == $past(periph_oe_in[pfm_pkg::PAD_JTAG_MODE][6]))
        else $error("mode select ball mode 6 not routed");

    AST_CLOCK_CAN: assert property (
        (ctl[pfm_pkg::PAD_JTAG_CLK].function_select == 4'h8
         && !ctl[pfm_pkg::PAD_JTAG_CLK].oe_force)
        |=> pad_drive_out[pfm_pkg::PAD_JTAG_CLK].oe
            == $past(periph_oe_in[pfm_pkg::PAD_JTAG_CLK][8]))
        else $error("clock ball mode 8 not routed");

    AST_DATA_IN_ALIAS: assert property (
        (reg_rd_in && !reg_wr_in && reg_addr_in == pfm_pkg::ADDR_JTAG_DATA_IN_ALIAS)
        |=> reg_rdata_out == $past(ctl[pfm_pkg::PAD_JTAG_DIN]) && !reg_err_out)
        else $error("data-in ball second address not answered");

    AST_RESTART_ONE_MODE: assert property (
        (ctl[pfm_pkg::PAD_RESTART].function_select != 4'h0
         && !ctl[pfm_pkg::PAD_RESTART].oe_force)
        |=> !pad_drive_out[pfm_pkg::PAD_RESTART].oe
            && periph_in_out[pfm_pkg::PAD_RESTART] == 16'h0000)
        else $error("restart ball answered a mode other than zero");

    COV_WRITE_READ: cover property (wr_hit_q ##1 (reg_rd_in && hit));
    COV_STRAP: cover property ($rose(strap_valid_out));
    COV_GPIO_MODE: cover property (ctl[pfm_pkg::PAD_SYNC_IN].function_select == 4'h0);
    COV_UNLISTED: cover property (!mode_ok(pfm_pkg::PAD_RESTART,
                                           ctl[pfm_pkg::PAD_RESTART].function_select));

endmodule

// ==== tb/tb.sv ====
/*
 * Self-checking bench for the pad function multiplexer: reset images,
 * boot straps, mode routing of every ball, pulls, overrides, refusals.
 * Assumes the shared package is compiled first and the design's assertions
 * live inside the design file.
 */
`timescale 1ns/1ps

module tb;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [31:0] reg_addr_in = 32'h0;
    logic reg_wr_in = 1'b0;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_rd_in = 1'b0;
    logic [31:0] reg_rdata_out;
    logic reg_ack_out;
    logic reg_err_out;
    logic [pfm_pkg::NUM_PADS-1:0] pad_in_in = '0;
    pfm_pkg::pfm_pad_drive_t [pfm_pkg::NUM_PADS-1:0] pad_drive_out;
    logic [pfm_pkg::NUM_PADS-1:0][15:0] periph_out_in = '0;
    logic [pfm_pkg::NUM_PADS-1:0][15:0] periph_oe_in = '0;
    logic [pfm_pkg::NUM_PADS-1:0][15:0] periph_in_out;
    logic [1:0] boot_sense_strap_out;
    logic strap_valid_out;
    int num_errors = 0;
    int compares = 0;
    logic [31:0] rd_val;
    logic [31:0] pull_words [3] = '{32'h00000001, 32'h00000201, 32'h00000301};

    pfm_pad_function_mux i_dut (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in),
        .reg_wdata_in(reg_wdata_in),
        .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out),
        .reg_ack_out(reg_ack_out),
        .reg_err_out(reg_err_out),
        .pad_in_in(pad_in_in),
        .pad_drive_out(pad_drive_out),
        .periph_out_in(periph_out_in),
        .periph_oe_in(periph_oe_in),
        .periph_in_out(periph_in_out),
        .boot_sense_strap_out(boot_sense_strap_out),
        .strap_valid_out(strap_valid_out)
    );

    // 50 MHz clock
    always #10 clk_in = ~clk_in;

    // ----------------------------------------------------------------
    // Compare and bus tasks
    // ----------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Narrow pad results, widened so one report format serves all
    task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
        chk_word({16'h0, got}, {16'h0, exp});
    endtask

    task automatic end_sim;
        if (num_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Strobe held one full cycle; ack is looked at in the cycle after
    task automatic reg_write(input logic [31:0] addr, input logic [31:0] data,
                             input logic err_exp);
        @(negedge clk_in);
        reg_addr_in = addr;
        reg_wdata_in = data;
        reg_wr_in = 1'b1;
        @(negedge clk_in);
        reg_wr_in = 1'b0;
        chk_pin({14'h0, reg_ack_out, reg_err_out}, {14'h0, 1'b1, err_exp});
    endtask

    task automatic reg_read(input logic [31:0] addr, input logic err_exp,
                            output logic [31:0] data);
        @(negedge clk_in);
        reg_addr_in = addr;
        reg_rd_in = 1'b1;
        @(negedge clk_in);
        reg_rd_in = 1'b0;
        chk_pin({14'h0, reg_ack_out, reg_err_out}, {14'h0, 1'b1, err_exp});
        data = reg_rdata_out;
    endtask

    // Reset for five cycles with strap levels on the two sensed balls
    task automatic apply_reset(input logic [1:0] straps);
        @(negedge clk_in);
        rst_n_in = 1'b0;
        pad_in_in = '0;
        pad_in_in[pfm_pkg::PAD_SYNC_OUT] = straps[1];
        pad_in_in[pfm_pkg::PAD_JTAG_DOUT] = straps[0];
        repeat (5) @(negedge clk_in);
        chk_pin({13'h0, strap_valid_out, boot_sense_strap_out}, 16'h0);
        for (int p = 0; p < pfm_pkg::NUM_PADS; p++) begin
            chk_pin({13'h0, pad_drive_out[p].oe, pad_drive_out[p].pull_en,
                     pad_drive_out[p].pull_up},
                    {13'h0, p == pfm_pkg::PAD_JTAG_DOUT,
                     !pfm_pkg::RESET_VALUE[p][8] && pfm_pkg::HAS_PULL[p],
                     !pfm_pkg::RESET_VALUE[p][8] && pfm_pkg::HAS_PULL[p]
                     && pfm_pkg::RESET_VALUE[p][9]});
        end
        rst_n_in = 1'b1;
        @(negedge clk_in);
        pad_in_in = ~pad_in_in;
        chk_pin({13'h0, strap_valid_out, boot_sense_strap_out}, {13'h0, 1'b1, straps});
        @(negedge clk_in);
        chk_pin({14'h0, boot_sense_strap_out}, {14'h0, straps});
        for (int p = 0; p < pfm_pkg::NUM_PADS; p++) begin
            reg_read(pfm_pkg::ADDR_TABLE[p], 1'b0, rd_val);
            chk_word(rd_val, pfm_pkg::RESET_VALUE[p]);
        end
    endtask

    // One override case on the serial B output ball
    task automatic ovr_case(input logic [31:0] word, input logic pin, input logic [15:0] poe,
                            input logic [1:0] exp_drv, input logic [15:0] exp_in);
        pad_in_in[pfm_pkg::PAD_SB_OUT] = pin;
        periph_oe_in[pfm_pkg::PAD_SB_OUT] = poe;
        periph_out_in[pfm_pkg::PAD_SB_OUT] = 16'h0002;
        reg_write(pfm_pkg::ADDR_SERIAL_B_OUT, word, 1'b0);
        @(negedge clk_in);
        chk_pin({14'h0, pad_drive_out[pfm_pkg::PAD_SB_OUT].out,
                 pad_drive_out[pfm_pkg::PAD_SB_OUT].oe}, {14'h0, exp_drv});
        chk_pin(periph_in_out[pfm_pkg::PAD_SB_OUT], exp_in);
    endtask

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    // Whole run is about one thousand cycles
    initial begin
        logic lst;
        apply_reset(2'b10);
        // Every ball through all sixteen codes; only the selected lane may answer
        for (int p = 0; p < pfm_pkg::NUM_PADS; p++) begin
            for (int m = 0; m < pfm_pkg::NUM_MODES; m++) begin
                lst = pfm_pkg::MODE_MASK[p][m];
                periph_out_in[p] = 16'h1 << m;
                periph_oe_in[p] = 16'h1 << m;
                pad_in_in[p] = 1'b1;
                reg_write(pfm_pkg::ADDR_TABLE[p], 32'h5a5a0100 | 32'(m), 1'b0);
                @(negedge clk_in);
                chk_pin(periph_in_out[p], lst ? (16'h1 << m) : 16'h0);
                if (!(p == pfm_pkg::PAD_RESTART && m == 0)) begin
                    chk_pin({14'h0, pad_drive_out[p].out, pad_drive_out[p].oe},
                            {14'h0, lst, lst});
                end
                reg_read(pfm_pkg::ADDR_TABLE[p], 1'b0, rd_val);
                chk_word(rd_val, 32'h5a5a0100 | 32'(m));
            end
            periph_out_in[p] = '0;
            periph_oe_in[p] = '0;
        end
        reg_read(pfm_pkg::ADDR_JTAG_DATA_IN_ALIAS, 1'b0, rd_val);
        chk_word(rd_val, 32'h5a5a010f);
        // Pull on-down, on-up, inhibited, on every ball
        for (int p = 0; p < pfm_pkg::NUM_PADS; p++) begin
            for (int v = 0; v < 3; v++) begin
                reg_write(pfm_pkg::ADDR_TABLE[p], pull_words[v], 1'b0);
                @(negedge clk_in);
                chk_pin({14'h0, pad_drive_out[p].pull_en,
                         pad_drive_out[p].pull_up & pad_drive_out[p].pull_en},
                        {14'h0, pfm_pkg::HAS_PULL[p] && !pull_words[v][8],
                         pfm_pkg::HAS_PULL[p] && !pull_words[v][8] && pull_words[v][9]});
            end
        end
        ovr_case(32'h00000041, 1'b1, 16'h0000, 2'b11, 16'h0002);
        ovr_case(32'h000000c1, 1'b1, 16'h0002, 2'b10, 16'h0002);
        ovr_case(32'h00000043, 1'b1, 16'h0002, 2'b01, 16'h0000);
        ovr_case(32'h00000031, 1'b0, 16'h0002, 2'b11, 16'h0002);
        ovr_case(32'h00000011, 1'b1, 16'h0002, 2'b11, 16'h0000);
        // Gap address between balls: refused, no side effect
        reg_write(32'hffffea04, 32'hffffffff, 1'b1);
        reg_read(32'hffffea04, 1'b1, rd_val);
        chk_word(rd_val, 32'h0);
        reg_read(pfm_pkg::ADDR_HOST_ATTENTION, 1'b0, rd_val);
        chk_word(rd_val, 32'h00000301);
        apply_reset(2'b01);
        end_sim();
    end

    // Watchdog far beyond the expected run length
    initial begin
        #200us;
        num_errors++;
        end_sim();
    end

endmodule
